// ### inc/spmb_regs.vh
// register offsets, field positions, reset values and clock divider counts
// for the buffered master/slave serial port; definitions only
`ifndef SPMB_REGS_VH
`define SPMB_REGS_VH

// ==========================================
// register offsets
`define SPMB_OFS_CTRL_A 3'h0
`define SPMB_OFS_CTRL_B 3'h1
`define SPMB_OFS_INT_EN 3'h2
`define SPMB_OFS_FLAGS 3'h3
`define SPMB_OFS_DATA 3'h4

// ==========================================
// reset values and writable masks
`define SPMB_RST_BYTE 8'h00
`define SPMB_MASK_CTRL_A 8'h77
`define SPMB_MASK_CTRL_B 8'hc7
`define SPMB_MASK_INT_EN 8'hf1
`define SPMB_SYNC_RST 4'h8

// ==========================================
// port_control_a fields
`define SPMB_A_BIT_ORDER 6
`define SPMB_A_MASTER 5
`define SPMB_A_CLOCK_DOUBLE 4
`define SPMB_A_CLOCK_PRESCALE_HI 2
`define SPMB_A_CLOCK_PRESCALE_LO 1
`define SPMB_A_ENABLE 0

// ==========================================
// port_control_b fields
`define SPMB_B_BUFFERED 7
`define SPMB_B_WAIT_RX 6
`define SPMB_B_SEL_DISABLE 2
`define SPMB_B_POLARITY 1
`define SPMB_B_PHASE 0

// ==========================================
// interrupt_enables and interrupt_flags fields
`define SPMB_I_RX_DONE 7
`define SPMB_I_TX_DONE 6
`define SPMB_I_TX_EMPTY 5
`define SPMB_I_SEL_TRIG 4
`define SPMB_I_LEGACY 0

// ==========================================
// serial clock half periods in peripheral clocks (divide by 4, 16, 64, 128)
`define SPMB_HALF_DIVIDE_BY_FOUR 7'h02
`define SPMB_HALF_DIV16 7'h08
`define SPMB_HALF_DIV64 7'h20
`define SPMB_HALF_DIVIDE_BY_128 7'h40
`define SPMB_LAST_EDGE 4'hf

`endif

// ### rtl/spmb_core.v
// byte-wide serial port that works as master or slave, with optional buffered mode
// assumes a byte register port on clock_in and pins synchronised internally
//
// Functional notes
// - bit_order_select 0 shifts msb first, 1 lsb first, both directions
// - master with select pin input low: clear master bit, set legacy flag
// - select_line_disable set: master ignores the select line
// - clock_double doubles the master serial clock rate
// - clock_prescale gives divide by 4, 16, 64, 128; slave ignores it
// - port works only while enable bit is one
// - buffered mode: two receive buffers, one transmit buffer, split flags
// - buffered, wait_for_receive 0: first byte sent is a dummy
// - buffered, wait_for_receive 1: idle write with select high loads shifter
// - mode field selects sampling and setup edges
// - serial clock idles low for rising leading edge, high otherwise
// - buffered enables gate their flags; read zero outside buffered mode
// - non-buffered: legacy enable gates the shared flag onto the interrupt
// - buffered rx_done_flag tracks unread bytes; write one clears it
// - legacy flag set on byte done or select takeover
// - legacy flag cleared by vector ack or flag read then data access
// - tx_done_flag set when shifter empty and no byte waits; write one clears
// - write_collision_flag set on data write during a byte
// - tx_empty_flag high while transmit buffer empty, zero outside buffered
// - buffered select takeover sets select_trigger_flag; write one clears
// - rx_overrun_flag set when third byte arrives with both buffers full
// - buffered data read returns second buffer, moves first into second
`timescale 1ns/1ps
`include "spmb_regs.vh"

module spmb_core (
  input wire clock_in,
  input wire reset_n_in,
  input wire clk_en_in,
  input wire [2:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [7:0] reg_rdata_out,
  input wire vector_ack_in,
  output reg irq_out,
  input wire select_is_input_in,
  input wire select_n_in,
  input wire sck_in,
  output wire sck_out,
  output reg sck_oe_n_out,
  input wire mosi_in,
  output wire mosi_out,
  output reg mosi_oe_n_out,
  input wire miso_in,
  output wire miso_out,
  output reg miso_oe_n_out
);

  // ==========================================
  // helpers
  function first_bit;
    input lsb_first;
    input [7:0] d;
    begin
      first_bit = lsb_first ? d[0] : d[7];
    end
  endfunction

  function [7:0] advance;
    input lsb_first;
    input [7:0] d;
    begin
      advance = lsb_first ? {1'b0, d[7:1]} : {d[6:0], 1'b0};
    end
  endfunction

  // ==========================================
  // pin synchronisers: ss, sck, mosi, miso
  wire [3:0] pin_raw = {select_n_in, sck_in, mosi_in, miso_in};
  reg [3:0] sync1;
  reg [3:0] sync2;
  reg [3:0] sync3;
  reg [3:0] pin_f;
  localparam [3:0] sync_rst_val = `SPMB_SYNC_RST;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
      always @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          sync1[gi] <= sync_rst_val[gi];
          sync2[gi] <= sync_rst_val[gi];
          sync3[gi] <= sync_rst_val[gi];
          pin_f[gi] <= sync_rst_val[gi];
        end else if (clk_en_in) begin
          sync1[gi] <= pin_raw[gi];
          sync2[gi] <= sync1[gi];
          sync3[gi] <= sync2[gi];
          if (sync2[gi] == sync3[gi]) begin
            pin_f[gi] <= sync3[gi];
          end
        end
      end
    end
  endgenerate
  wire ss_f = pin_f[3];
  wire sck_f = pin_f[2];
  wire mosi_f = pin_f[1];
  wire miso_f = pin_f[0];

  // ==========================================
  // state
  reg [7:0] ctrl_a;
  reg [7:0] ctrl_b;
  reg [7:0] int_en;
  reg if_flag;
  reg write_collision_flag;
  reg rxc;
  reg txc;
  reg select_trigger_flag;
  reg ovf;
  reg armed;
  reg txbuf_full;
  reg loaded;
  reg [7:0] txbuf;
  reg [7:0] txsh;
  reg [7:0] rxsh;
  reg [7:0] rxb1;
  reg [7:0] rxb2;
  reg v1;
  reg v2;
  reg out_bit;
  reg busy_m;
  reg [6:0] div_cnt;
  reg [3:0] edge_cnt;
  reg sck_lvl;
  reg sck_q;

  wire en = ctrl_a[`SPMB_A_ENABLE];
  wire master = ctrl_a[`SPMB_A_MASTER];
  wire bit_order_select = ctrl_a[`SPMB_A_BIT_ORDER];
  wire buffered_mode_on = ctrl_b[`SPMB_B_BUFFERED];
  wire wait_for_receive = ctrl_b[`SPMB_B_WAIT_RX];
  wire select_line_disable = ctrl_b[`SPMB_B_SEL_DISABLE];
  wire cpol = ctrl_b[`SPMB_B_POLARITY];
  wire cpha = ctrl_b[`SPMB_B_PHASE];

  // ==========================================
  // serial clock rate
  reg [6:0] half;
  always @* begin
    case (ctrl_a[`SPMB_A_CLOCK_PRESCALE_HI:`SPMB_A_CLOCK_PRESCALE_LO])
      2'h0: half = `SPMB_HALF_DIVIDE_BY_FOUR;
      2'h1: half = `SPMB_HALF_DIV16;
      2'h2: half = `SPMB_HALF_DIV64;
      default: half = `SPMB_HALF_DIVIDE_BY_128;
    endcase
    if (ctrl_a[`SPMB_A_CLOCK_DOUBLE]) begin
      half = {1'b0, half[6:1]};
    end
  end

  // ==========================================
  // edge events
  wire takeover = en & master & select_is_input_in & ~select_line_disable & ~ss_f;
  wire slv_act = en & ~master & ~ss_f;
  wire m_edge = busy_m & (div_cnt == 7'h00);
  wire s_edge = slv_act & (sck_f != sck_q);
  wire edge_ev = master ? m_edge : s_edge;
  wire leading = master ? ~edge_cnt[0] : (sck_f != cpol);
  wire sample = edge_ev & (leading ^ cpha);
  wire setup = edge_ev & ~(leading ^ cpha);
  wire in_bit = master ? miso_f : mosi_f;
  wire [7:0] rx_next = bit_order_select ? {in_bit, rxsh[7:1]} : {rxsh[6:0], in_bit};
  wire [7:0] rx_byte = sample ? rx_next : rxsh;
  wire done = edge_ev & (edge_cnt == `SPMB_LAST_EDGE);
  wire busy = master ? busy_m : (edge_cnt != 4'h0);

  wire wr_data = reg_wr_in & (reg_addr_in == `SPMB_OFS_DATA);
  wire rd_data = reg_rd_in & (reg_addr_in == `SPMB_OFS_DATA);
  wire rd_flags = reg_rd_in & (reg_addr_in == `SPMB_OFS_FLAGS);
  wire wr_flags = reg_wr_in & (reg_addr_in == `SPMB_OFS_FLAGS);
  wire rd_buf = rd_data & buffered_mode_on;
  wire direct = buffered_mode_on & wait_for_receive & en & ss_f & ~busy & ~loaded & ~txbuf_full;
  wire go = en & master & ~busy_m & (loaded | txbuf_full) & ~takeover;
  wire w2 = rd_buf ? v1 : v2;
  wire w1 = rd_buf ? 1'b0 : v1;

  wire [7:0] flags_view = {buffered_mode_on ? rxc : if_flag, buffered_mode_on ? txc : write_collision_flag,
    buffered_mode_on & ~txbuf_full, buffered_mode_on & select_trigger_flag, 3'h0, buffered_mode_on & ovf};
  wire [7:0] en_view = {int_en[7:4] & {4{buffered_mode_on}}, 3'h0, int_en[0]};

  // ==========================================
  // main sequential logic
  always @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctrl_a <= `SPMB_RST_BYTE;
      ctrl_b <= `SPMB_RST_BYTE;
      int_en <= `SPMB_RST_BYTE;
      if_flag <= 1'b0;
      write_collision_flag <= 1'b0;
      rxc <= 1'b0;
      txc <= 1'b0;
      select_trigger_flag <= 1'b0;
      ovf <= 1'b0;
      armed <= 1'b0;
      txbuf_full <= 1'b0;
      loaded <= 1'b0;
      txbuf <= `SPMB_RST_BYTE;
      txsh <= `SPMB_RST_BYTE;
      rxsh <= `SPMB_RST_BYTE;
      rxb1 <= `SPMB_RST_BYTE;
      rxb2 <= `SPMB_RST_BYTE;
      v1 <= 1'b0;
      v2 <= 1'b0;
      out_bit <= 1'b0;
      busy_m <= 1'b0;
      div_cnt <= 7'h00;
      edge_cnt <= 4'h0;
      sck_lvl <= 1'b0;
      sck_q <= 1'b0;
      reg_rdata_out <= `SPMB_RST_BYTE;
      irq_out <= 1'b0;
      sck_oe_n_out <= 1'b1;
      mosi_oe_n_out <= 1'b1;
      miso_oe_n_out <= 1'b1;
    end else if (clk_en_in) begin
      sck_q <= sck_f;
      // register reads, data one cycle later
      if (reg_rd_in) begin
        case (reg_addr_in)
          `SPMB_OFS_CTRL_A: reg_rdata_out <= ctrl_a;
          `SPMB_OFS_CTRL_B: reg_rdata_out <= ctrl_b;
          `SPMB_OFS_INT_EN: reg_rdata_out <= en_view;
          `SPMB_OFS_FLAGS: reg_rdata_out <= flags_view;
          `SPMB_OFS_DATA: reg_rdata_out <= rxb2;
          default: reg_rdata_out <= `SPMB_RST_BYTE;
        endcase
      end
      // register writes
      if (reg_wr_in && reg_addr_in == `SPMB_OFS_CTRL_A) begin
        ctrl_a <= reg_wdata_in & `SPMB_MASK_CTRL_A;
      end
      if (reg_wr_in && reg_addr_in == `SPMB_OFS_CTRL_B) begin
        ctrl_b <= reg_wdata_in & `SPMB_MASK_CTRL_B;
      end
      if (reg_wr_in && reg_addr_in == `SPMB_OFS_INT_EN) begin
        int_en <= reg_wdata_in & `SPMB_MASK_INT_EN;
      end
      if (wr_flags && buffered_mode_on) begin
        if (reg_wdata_in[`SPMB_I_RX_DONE]) begin
          rxc <= 1'b0;
        end
        if (reg_wdata_in[`SPMB_I_TX_DONE]) begin
          txc <= 1'b0;
        end
        if (reg_wdata_in[`SPMB_I_SEL_TRIG]) begin
          select_trigger_flag <= 1'b0;
        end
      end
      // legacy flag clearing sequence
      if (rd_flags && !buffered_mode_on && (if_flag || write_collision_flag)) begin
        armed <= 1'b1;
      end
      if (armed && (rd_data || wr_data)) begin
        armed <= 1'b0;
        if_flag <= 1'b0;
        write_collision_flag <= 1'b0;
      end
      if (vector_ack_in) begin
        if_flag <= 1'b0;
      end
      // receive buffer read
      if (rd_buf) begin
        rxb2 <= rxb1;
        v2 <= v1;
        v1 <= 1'b0;
        ovf <= 1'b0;
        if (!v1 && !done) begin
          rxc <= 1'b0;
        end
      end
      // data writes
      if (wr_data) begin
        if (!buffered_mode_on) begin
          if (busy) begin
            write_collision_flag <= 1'b1;
          end else begin
            loaded <= 1'b1;
            txsh <= cpha ? reg_wdata_in : advance(bit_order_select, reg_wdata_in);
            out_bit <= first_bit(bit_order_select, reg_wdata_in);
          end
        end else if (direct) begin
          loaded <= 1'b1;
          txsh <= cpha ? reg_wdata_in : advance(bit_order_select, reg_wdata_in);
          out_bit <= first_bit(bit_order_select, reg_wdata_in);
        end else if (!txbuf_full) begin
          txbuf <= reg_wdata_in;
          txbuf_full <= 1'b1;
        end
      end
      // master clock generator
      if (go) begin
        busy_m <= 1'b1;
        loaded <= 1'b0;
        div_cnt <= half - 7'h01;
        edge_cnt <= 4'h0;
      end else if (busy_m) begin
        if (m_edge) begin
          sck_lvl <= ~sck_lvl;
          div_cnt <= half - 7'h01;
        end else begin
          div_cnt <= div_cnt - 7'h01;
        end
      end else begin
        sck_lvl <= cpol;
      end
      // shifting on selected edges
      if (edge_ev) begin
        edge_cnt <= edge_cnt + 4'h1;
        if (edge_cnt == 4'h0 && !master) begin
          loaded <= 1'b0;
        end
      end
      if (sample) begin
        rxsh <= rx_next;
      end
      if (setup) begin
        out_bit <= first_bit(bit_order_select, txsh);
        txsh <= advance(bit_order_select, txsh);
      end
      // end of byte
      if (done) begin
        busy_m <= 1'b0;
        if (!buffered_mode_on) begin
          if_flag <= 1'b1;
          rxb2 <= rx_byte;
          txsh <= cpha ? rx_byte : advance(bit_order_select, rx_byte);
          out_bit <= cpha ? out_bit : first_bit(bit_order_select, rx_byte);
        end else begin
          rxc <= 1'b1;
          if (!w2) begin
            rxb2 <= rx_byte;
            v2 <= 1'b1;
          end else if (!w1) begin
            rxb1 <= rx_byte;
            v1 <= 1'b1;
          end else begin
            ovf <= 1'b1;
          end
          if (txbuf_full) begin
            txbuf_full <= 1'b0;
            loaded <= 1'b1;
            txsh <= cpha ? txbuf : advance(bit_order_select, txbuf);
            out_bit <= cpha ? out_bit : first_bit(bit_order_select, txbuf);
          end else begin
            txc <= 1'b1;
            txsh <= cpha ? rx_byte : advance(bit_order_select, rx_byte);
            // last edge samples when cpha is set: hold the line, next leading edge sets up
            out_bit <= cpha ? out_bit : first_bit(bit_order_select, rx_byte);
          end
        end
      end
      // select line takeover ends master mode
      if (takeover) begin
        ctrl_a[`SPMB_A_MASTER] <= 1'b0;
        if_flag <= 1'b1;
        if (buffered_mode_on) begin
          select_trigger_flag <= 1'b1;
        end
        busy_m <= 1'b0;
        edge_cnt <= 4'h0;
      end
      // disabled port or deselected slave drops the byte in flight
      if (!en || (!master && ss_f)) begin
        busy_m <= 1'b0;
        edge_cnt <= 4'h0;
        sck_lvl <= cpol;
      end
      irq_out <= buffered_mode_on ? |(int_en[7:4] & {rxc, txc, ~txbuf_full, select_trigger_flag})
        : (int_en[`SPMB_I_LEGACY] & if_flag);
      sck_oe_n_out <= ~(en & master);
      mosi_oe_n_out <= ~(en & master);
      miso_oe_n_out <= ~slv_act;
    end
  end

  assign sck_out = sck_lvl;
  assign mosi_out = out_bit;
  assign miso_out = out_bit;

endmodule

// ### sim/spmb_asserts.sv
// checker: serial clock timing, mastership, enable and register views
// assumes clk_en_in stays high, so the shadows follow every register write
`timescale 1ns/1ps
module spmb_asserts (
  input wire clock_in,
  input wire reset_n_in,
  input wire [2:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [7:0] reg_rdata_out,
  input wire irq_out,
  input wire select_is_input_in,
  input wire select_n_in,
  input wire sck_out,
  input wire sck_oe_n_out,
  input wire mosi_out,
  input wire mosi_oe_n_out,
  input wire miso_oe_n_out
);
  // ==========
  // shadows of settings and run length of the serial clock level
  reg [7:0] sa, sb, se, run;
  reg sck_d, mosi_d;
  wire pol = sb[1];
  wire [6:0] base = sa[2] ? (sa[1] ? 7'h40 : 7'h20) : (sa[1] ? 7'h08 : 7'h02);
  wire [7:0] half = {1'b0, sa[4] ? base >> 1 : base};
  wire gate = |(se & (sb[7] ? 8'hf0 : 8'h01));
  always @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sa <= 8'h00;
      sb <= 8'h00;
      se <= 8'h00;
      run <= 8'h00;
      sck_d <= 1'b0;
      mosi_d <= 1'b0;
    end else begin
      if (reg_wr_in && reg_addr_in == 3'h0) sa <= reg_wdata_in;
      if (reg_wr_in && reg_addr_in == 3'h1) sb <= reg_wdata_in;
      if (reg_wr_in && reg_addr_in == 3'h2) se <= reg_wdata_in;
      run <= (sck_out != sck_d) ? 8'h01 : run + {7'h00, run != 8'hff};
      sck_d <= sck_out;
      mosi_d <= mosi_out;
    end
  end
  default clocking dclk @(posedge clock_in);
  endclocking
  default disable iff (!reset_n_in);
  // ==========
  // assertions
  clk_idle_a: assert property (
    run == 8'h64 && !sck_oe_n_out |-> sck_out == pol)
    else $error("serial clock away from idle level");
  half_period_a: assert property (
    !sck_oe_n_out && sck_out != sck_d && sck_d != pol |-> run == half)
    else $error("serial clock half period wrong");
  sample_edge_a: assert property (
    !sck_oe_n_out && sck_out != sck_d && ((sck_d == pol) != sb[0]) |-> mosi_out == mosi_d)
    else $error("data moved on a sampling edge");
  takeover_a: assert property (
    $fell(select_n_in) && select_is_input_in && !sb[2] && !mosi_oe_n_out
      |-> ##[1:8] mosi_oe_n_out)
    else $error("master kept despite select low");
  keep_master_a: assert property (
    sb[2] && !select_n_in && !mosi_oe_n_out && !reg_wr_in && !$past(reg_wr_in)
      |=> !mosi_oe_n_out)
    else $error("master dropped with select disabled");
  port_off_a: assert property (
    !sa[0] && !$past(sa[0]) |-> sck_oe_n_out && mosi_oe_n_out && miso_oe_n_out)
    else $error("disabled port drives a pin");
  enable_view_a: assert property (
    !sb[7] && reg_rd_in && reg_addr_in == 3'h2 |=> reg_rdata_out == {7'h00, se[0]})
    else $error("buffered enables visible when unbuffered");
  flag_view_a: assert property (
    !sb[7] && reg_rd_in && reg_addr_in == 3'h3 |=> reg_rdata_out[5:0] == 6'h00)
    else $error("buffered flags visible when unbuffered");
  irq_gate_a: assert property (
    !$past(gate) |-> !irq_out)
    else $error("interrupt without enable");
endmodule

bind spmb_core spmb_asserts u_spmb_asserts (.clock_in, .reset_n_in, .reg_addr_in,
  .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .irq_out, .select_is_input_in,
  .select_n_in, .sck_out, .sck_oe_n_out, .mosi_out, .mosi_oe_n_out, .miso_oe_n_out);

// ### sim/spmb_peer.sv
// far-side serial slave: samples the data line, answers on the return line
// assumes the bench selects it and gives mode and bit order
`timescale 1ns/1ps
module spmb_peer (
  input wire sck_in,
  input wire mosi_in,
  input wire sel_n_in,
  input wire [1:0] mode_in,
  input wire lsb_in,
  input wire [7:0] tx_in,
  output logic miso_out = 1'b0,
  output logic [7:0] rx_out = 8'h00,
  output logic [7:0] frames_out = 8'h00
);
  logic [3:0] cnt = 4'h0;
  logic [7:0] cur;
  // ==========
  // bit engine; each byte answered is tx_in plus bytes already done
  always @(negedge sel_n_in) begin
    cnt = 4'h0;
    frames_out = 8'h00;
    cur = tx_in;
    if (!mode_in[0]) miso_out = lsb_in ? cur[0] : cur[7];
  end
  // released line has no pull: show the inverse
  always @(posedge sel_n_in) miso_out = ~miso_out;
  always @(sck_in) begin
    if (!sel_n_in && ((sck_in != mode_in[1]) != mode_in[0])) begin
      rx_out = lsb_in ? {mosi_in, rx_out[7:1]} : {rx_out[6:0], mosi_in};
      cnt = cnt + 4'h1;
    end else if (!sel_n_in) begin
      if (cnt == 4'h8) begin
        cnt = 4'h0;
        frames_out = frames_out + 8'h01;
        cur = tx_in + frames_out;
      end
      miso_out = lsb_in ? cur[cnt[2:0]] : cur[3'h7 - cnt[2:0]];
    end
  end
endmodule

// ### sim/spmb_core_tb.sv
// bench for the serial port core: register tasks against a far-side slave
// assumes a 200 MHz clock and the core's register map
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module spmb_core_tb;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, ack = 1'b0, sel_in = 1'b0, sel_n = 1'b1;
  logic lsb = 1'b0, psel_n = 1'b1, tsck = 1'b0;
  logic [1:0] mode = 2'h0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00, ptx = 8'h00, got;
  int failures = 0, cmp_count = 0;
  wire [7:0] rdata, prx, pfr;
  wire irq, sck, sck_oe_n, mosi, mosi_oe_n, miso, miso_oe_n, pmiso;
  wire sck_pin = sck_oe_n ? (mode[1] ^ tsck) : sck;
  wire mosi_pin = mosi_oe_n ? ~mosi : mosi;
  wire miso_pin = miso_oe_n ? pmiso : miso;
  always #2.5 clk = ~clk;
  spmb_core u_spmb_core (.clock_in(clk), .reset_n_in(rst_n), .clk_en_in(1'b1),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .vector_ack_in(ack), .irq_out(irq), .select_is_input_in(sel_in),
    .select_n_in(sel_n), .sck_in(sck_pin), .sck_out(sck), .sck_oe_n_out(sck_oe_n),
    .mosi_in(mosi_pin), .mosi_out(mosi), .mosi_oe_n_out(mosi_oe_n), .miso_in(miso_pin),
    .miso_out(miso), .miso_oe_n_out(miso_oe_n));
  spmb_peer u_spmb_peer (.sck_in(sck_pin), .mosi_in(mosi_pin), .sel_n_in(psel_n),
    .mode_in(mode), .lsb_in(lsb), .tx_in(ptx), .miso_out(pmiso), .rx_out(prx),
    .frames_out(pfr));
  // ==========
  // register access
  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rreg(input logic [2:0] a);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 got = rdata;
    @(posedge clk);
  endtask
  task automatic rchk(input logic [2:0] a, input logic [7:0] e, input string n);
    rreg(a);
    `CHK(n, e, got)
  endtask
  task automatic wait_bit(input int b);
    got = 8'h00;
    for (int k = 0; k < 900 && got[b] !== 1'b1; k++) rreg(3'h3);
    `CHK("flag wait", 1'b1, got[b])
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #400_000;
    failures++;
    $display("[ERR] watchdog exp done got hang");
    close_out;
  end
  // ==========
  // tests
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int a = 0; a < 6; a++) rchk(a[2:0], 8'h00, "reset");
    wreg(3'h1, 8'hff);
    wreg(3'h0, 8'hff);
    wreg(3'h2, 8'hff);
    rchk(3'h0, 8'h77, "ctrl a");
    rchk(3'h1, 8'hc7, "ctrl b");
    rchk(3'h2, 8'hf1, "enables");
    wreg(3'h0, 8'h00);
    wreg(3'h1, 8'h00);
    rchk(3'h2, 8'h01, "enables");
    $display("registers done");
    for (int i = 0; i < 8; i++) begin
      got = 8'h00;
      mode <= i[1:0];
      lsb <= i[2];
      ptx <= 8'h3c + 8'(i);
      wreg(3'h1, {6'h00, i[1:0]});
      wreg(3'h0, {1'b0, i[2], 1'b1, i[0], 1'b0, i[1:0], 1'b1});
      psel_n <= 1'b0;
      wreg(3'h4, 8'h96 ^ 8'(i));
      if (i == 0) wreg(3'h4, 8'h55);
      wait_irq;
      `CHK("sent", 8'h96 ^ 8'(i), prx)
      if (i[0]) begin
        ack <= 1'b1;
        @(posedge clk);
        ack <= 1'b0;
        rchk(3'h3, 8'h00, "acked");
      end else begin
        rchk(3'h3, (i == 0) ? 8'hc0 : 8'h80, "flags");
      end
      if (i[1]) rchk(3'h4, 8'h3c + 8'(i), "rx");
      else rreg(3'h4);
      rchk(3'h3, 8'h00, "cleared");
      psel_n <= 1'b1;
      wreg(3'h0, 8'h00);
    end
    $display("transfers done");
    mode <= 2'h0;
    lsb <= 1'b0;
    wreg(3'h1, 8'h04);
    wreg(3'h0, 8'h23);
    sel_in <= 1'b1;
    sel_n <= 1'b0;
    repeat (20) @(posedge clk);
    rchk(3'h0, 8'h23, "kept");
    sel_n <= 1'b1;
    repeat (8) @(posedge clk);
    wreg(3'h1, 8'h00);
    sel_n <= 1'b0;
    repeat (10) @(posedge clk);
    rchk(3'h0, 8'h03, "dropped");
    rchk(3'h3, 8'h80, "takeover");
    sel_n <= 1'b1;
    rreg(3'h4);
    wreg(3'h1, 8'h80);
    repeat (8) @(posedge clk);
    wreg(3'h0, 8'h23);
    sel_n <= 1'b0;
    repeat (10) @(posedge clk);
    rchk(3'h3, 8'h30, "trigger");
    wreg(3'h3, 8'h10);
    rchk(3'h3, 8'h20, "untrigger");
    sel_n <= 1'b1;
    sel_in <= 1'b0;
    repeat (8) @(posedge clk);
    wreg(3'h0, 8'h23);
    ptx <= 8'ha5;
    psel_n <= 1'b0;
    wreg(3'h4, 8'h43);
    wait_bit(6);
    `CHK("data after dummy", 8'h43, prx)
    `CHK("bytes", 8'h02, pfr)
    rchk(3'h3, 8'he0, "chain");
    rchk(3'h4, 8'ha5, "older");
    rchk(3'h4, 8'ha6, "newer");
    rchk(3'h3, 8'h60, "rx empty");
    wreg(3'h3, 8'h40);
    rchk(3'h3, 8'h20, "tx clear");
    for (int k = 0; k < 3; k++) begin
      wreg(3'h4, 8'h50);
      wait_bit(6);
      wreg(3'h3, 8'h40);
    end
    rchk(3'h3, 8'ha1, "overrun");
    rreg(3'h4);
    rchk(3'h3, 8'ha0, "overrun read");
    rreg(3'h4);
    psel_n <= 1'b1;
    wreg(3'h1, 8'hc0);
    psel_n <= 1'b0;
    wreg(3'h4, 8'h61);
    wait_bit(6);
    `CHK("direct", 8'h61, prx)
    `CHK("direct bytes", 8'h01, pfr)
    $display("buffered done");
    // slave: the bench clocks the link, the data line loops back inverted
    wreg(3'h1, 8'h00);
    wreg(3'h0, 8'h01);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    rchk(3'h3, 8'h00, "slave idle");
    wreg(3'h4, 8'hb4);
    sel_n <= 1'b0;
    repeat (8) @(posedge clk);
    `CHK("slave drive", 1'b0, miso_oe_n)
    `CHK("slave first", 1'b1, miso)
    for (int k = 0; k < 16; k++) begin
      tsck <= ~tsck;
      repeat (8) @(posedge clk);
    end
    rchk(3'h3, 8'h80, "slave flag");
    rchk(3'h4, 8'h4b, "slave rx");
    sel_n <= 1'b1;
    $display("slave done");
    close_out;
  end
  task automatic wait_irq;
    for (int k = 0; k < 3000 && irq !== 1'b1; k++) @(posedge clk);
    `CHK("irq", 1'b1, irq)
  endtask
endmodule
